// ===== hdl/twae_pkg.sv
/*
 * Constants for the two-wire addressing and event block: register offsets,
 * field positions, reset values, address patterns and divider figures.
 * Assumes a single 20 MHz clock domain and an 8-bit register port.
 */
package twae_pkg;
	// Register offsets on the 3-bit register port
	localparam logic [2:0] OFF_OWN_SLAVE_ADDRESS = 3'h0;
	localparam logic [2:0] OFF_BAUD_DIVIDER = 3'h1;
	localparam logic [2:0] OFF_MAIN_CONTROL = 3'h2;
	localparam logic [2:0] OFF_BUS_STATUS = 3'h3;
	localparam logic [2:0] OFF_TRANSFER_BYTE = 3'h4;
	localparam logic [2:0] OFF_ADDRESS_CONFIG = 3'h5;
	// main_control fields
	localparam int CTL_ENABLE = 7;
	localparam int CTL_IRQ_ENABLE = 6;
	localparam int CTL_MASTER = 5;
	localparam int CTL_TX = 4;
	localparam int CTL_ACK_DISABLE = 3;
	localparam int CTL_REPEAT_START = 2;
	// bus_status fields
	localparam int STS_BYTE_DONE = 7;
	localparam int STS_ADDRESSED = 6;
	localparam int STS_BUSY = 5;
	localparam int STS_ARB_LOST = 4;
	localparam int STS_SLAVE_DIR = 2;
	localparam int STS_IRQ_FLAG = 1;
	localparam int STS_RX_ACK = 0;
	// address_config fields
	localparam int CFG_GEN_CALL = 7;
	localparam int CFG_TEN_BIT = 6;
	// baud_divider fields
	localparam int BAUD_SCALE_MSB = 7;
	localparam int BAUD_SCALE_LSB = 6;
	localparam int BAUD_RATE_MSB = 5;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_TIMER = 10'h000;
	// Address patterns
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	// Bit counter figures
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	// Serial clock divider: base plus two per step of the rate field
	localparam logic [9:0] SCL_DIV_BASE = 10'h014;
	// Clock period in ns, for reference by the bench
	localparam int CLK_PERIOD_NS = 50;
endpackage : twae_pkg

// ===== hdl/twae_ctrl.sv
/*
 * Two-wire bus controller core: 7/10-bit slave addressing, general call,
 * status flags with one interrupt, arbitration-loss detection, master
 * clock generation from the baud divider.
 * Assumes open-drain pins resolved outside, pins asynchronous to ref_clk_in.
 */
// Overview of operation
// [RULE1] Ten-bit first address byte is 11110, two upper address bits, direction bit.
// [RULE2] After start, ten-bit slave acks first byte when prefix and bits match, write.
// [RULE3] Matched ten-bit slave acks second byte only on exact low-bit match.
// [RULE4] Selection lasts until stop or repeated start with another address.
// [RULE5] First ten-bit byte raises interrupt; software discards the data byte then.
// [RULE6] Remembered ten-bit slave acks repeated prefix with read and turns transmitter.
// [RULE7] Unselected slaves ignore repeated start prefix with read direction.
// [RULE8] General call accepted when enabled, slave receiver, addressed flag set.
// [RULE9] Software reads data byte; zero means general call.
// [RULE10] General call disabled: no acknowledge, following data ignored.
// [RULE11] Controller disabled after reset and never causes a system reset.
// [RULE12] Single interrupt output is flag gated by enable bit.
// [RULE13] Interrupt flag cleared only by writing one; zero leaves it.
// [RULE14] Byte done, address match or arbitration loss set interrupt flag.
// [RULE15] Byte done flag set at falling edge of ninth clock.
// [RULE16] Addressed flag set on own address or enabled general call.
// [RULE17] Software copies slave direction bit into transmit control on match.
// [RULE18] Master loses arbitration seeing data low while releasing, data or ack.
// [RULE19] Also lost: start while busy, repeat start as slave, unrequested stop.
// [RULE20] Arbitration-lost bit stays until software writes one.
// [RULE21] Serial rate is clock over two times multiplier times divider.
// [RULE22] Own address holds bits 7..1; upper three bits in address config.
// [RULE23] Ten-bit select zero means 7-bit, one means 10-bit addressing.
// [RULE24] Receiver acks by pulling data low during ninth clock.
// [RULE25] Addressed flag clears on control write or new start.
module twae_ctrl (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out
);
	typedef enum logic [4:0] {
		PH_IDLE = 5'b00001,
		PH_ADDR = 5'b00010,
		PH_ADDR2 = 5'b00100,
		PH_DATA = 5'b01000,
		PH_SKIP = 5'b10000
	} twae_phase_e;
	typedef enum logic [5:0] {
		M_IDLE = 6'b000001,
		M_START = 6'b000010,
		M_HOLD = 6'b000100,
		M_XFER = 6'b001000,
		M_RESTART = 6'b010000,
		M_STOP = 6'b100000
	} twae_mstate_e;

	function automatic logic twae_hit(input logic [2:0] a, input logic [2:0] off);
		twae_hit = a == off;
	endfunction : twae_hit

	logic [7:0] own_slave_address, baud_divider, address_config, shreg;
	logic en, ie, master_select, tx, ack_disable;
	logic byte_done_flag, addressed_as_slave, busy, arbitration_lost;
	logic slave_direction, bus_irq_flag, received_ack;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic [3:0] cnt;
	logic ack_en, sel10, m_ovr, m_force, m_step, m_go;
	logic [9:0] tmr, half;
	twae_phase_e ph, next_ph;
	twae_mstate_e mstate;
	logic wr_ctl, wr_sts, wr_dat, rd_dat;
	logic scl_rise, scl_fall, start_ev, stop_ev, dec, ev_byte;
	logic m_act, transmitting, data_pull;
	logic arb_bit, arb_busy, arb_repeat_start_request, arb_stop, ev_arb;
	logic [7:0] abyte;
	logic pre_hit, gc_hit, own7, low10;
	logic next_ack, set_addressed, next_slave_direction, next_sel10, ev10;

	assign wr_ctl = wr_in & twae_hit(addr_in, twae_pkg::OFF_MAIN_CONTROL);
	assign wr_sts = wr_in & twae_hit(addr_in, twae_pkg::OFF_BUS_STATUS);
	assign wr_dat = wr_in & twae_hit(addr_in, twae_pkg::OFF_TRANSFER_BYTE);
	assign rd_dat = rd_in & twae_hit(addr_in, twae_pkg::OFF_TRANSFER_BYTE);

	// Pin synchronisers, then one stage of history for edges
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			{scl_m, scl_s, scl_p} <= 3'b111;
			{sda_m, sda_s, sda_p} <= 3'b111;
		end else begin
			{scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
		end
	end

	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_ev = en & scl_s & scl_p & sda_p & ~sda_s;
	assign stop_ev = en & scl_s & scl_p & ~sda_p & sda_s;
	assign dec = en & scl_rise & (cnt == twae_pkg::LAST_DATA_BIT);
	assign ev_byte = en & scl_fall & (cnt == twae_pkg::ACK_BIT); // [RULE15]
	assign m_act = mstate != M_IDLE;

	// Divider: half period = multiplier x divider, full period twice that
	always_comb begin
		logic [9:0] div;
		div = twae_pkg::SCL_DIV_BASE + {3'b000, baud_divider[twae_pkg::BAUD_RATE_MSB:0], 1'b0};
		unique case (baud_divider[twae_pkg::BAUD_SCALE_MSB:twae_pkg::BAUD_SCALE_LSB])
			2'b01: half = {div[8:0], 1'b0}; // [RULE21]
			2'b10: half = {div[7:0], 2'b00}; // [RULE21]
			default: half = div; // [RULE21]
		endcase
	end

	// Bit counter and shared shift register
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !en || stop_ev) begin
			cnt <= 4'h0;
		end else if (start_ev) begin
			// One below zero: the clock fall that ends a start is no bit
			cnt <= 4'hF;
		end else if (ev_byte) begin
			cnt <= 4'h0;
		end else if (scl_fall) begin
			cnt <= cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			shreg <= twae_pkg::RST_BYTE;
		end else if (wr_dat) begin
			shreg <= wdata_in;
		end else if (en && scl_rise && cnt <= twae_pkg::LAST_DATA_BIT) begin
			shreg <= {shreg[6:0], sda_s};
		end
	end

	// Address decision at the last data bit of each byte
	assign abyte = {shreg[6:0], sda_s};
	assign pre_hit = abyte[7:3] == twae_pkg::TEN_BIT_PREFIX
		&& abyte[2:1] == address_config[2:1]; // [RULE1]
	assign gc_hit = abyte == twae_pkg::GEN_CALL_ADDR;
	assign own7 = abyte[7:1] == own_slave_address[7:1]
		&& abyte[7:3] != twae_pkg::TEN_BIT_PREFIX; // [RULE7]
	assign low10 = abyte == {address_config[0], own_slave_address[7:1]}; // [RULE22]

	always_comb begin
		next_ph = ph;
		next_ack = 1'b0;
		set_addressed = 1'b0;
		next_slave_direction = slave_direction;
		next_sel10 = sel10;
		ev10 = 1'b0;
		if (m_act) begin
			next_ack = ~tx & ~ack_disable;
		end else begin
			unique case (ph)
				PH_ADDR: begin
					next_ph = PH_SKIP;
					next_sel10 = 1'b0; // [RULE4]
					if (gc_hit) begin
						if (address_config[twae_pkg::CFG_GEN_CALL]) begin
							next_ph = PH_DATA; // [RULE8]
							next_ack = 1'b1;
							set_addressed = 1'b1;
							next_slave_direction = 1'b0;
						end
					end else if (address_config[twae_pkg::CFG_TEN_BIT]) begin // [RULE23]
						if (pre_hit && !abyte[0]) begin
							next_ph = PH_ADDR2; // [RULE2]
							next_ack = 1'b1;
							ev10 = 1'b1; // [RULE5]
						end else if (pre_hit && sel10) begin
							next_ph = PH_DATA; // [RULE6]
							next_ack = 1'b1;
							set_addressed = 1'b1;
							next_slave_direction = 1'b1;
							next_sel10 = 1'b1;
						end
					end else if (own7) begin
						next_ph = PH_DATA; // [RULE16]
						next_ack = 1'b1;
						set_addressed = 1'b1;
						next_slave_direction = abyte[0];
					end
				end
				PH_ADDR2: begin
					next_ph = low10 ? PH_DATA : PH_SKIP; // [RULE3]
					next_ack = low10;
					set_addressed = low10;
					next_slave_direction = 1'b0;
					next_sel10 = low10;
				end
				PH_DATA: begin
					next_ack = ~slave_direction & ~ack_disable;
				end
				default: begin
					next_ack = 1'b0; // [RULE10]
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !en || stop_ev) begin
			ph <= PH_IDLE; // [RULE4]
			sel10 <= 1'b0;
			ack_en <= 1'b0;
		end else if (start_ev) begin
			ph <= PH_ADDR;
			ack_en <= 1'b0;
		end else if (dec) begin
			ph <= next_ph;
			sel10 <= next_sel10;
			ack_en <= next_ack;
		end else if (ev_byte) begin
			ack_en <= 1'b0;
		end
	end

	// Data line drive: bits change only while the clock is low; start/stop override and arbitration release act at any time
	// Slave transmitter lets go of the data line after a missing acknowledge
	assign transmitting = m_act ? tx : (ph == PH_DATA) & slave_direction & ~received_ack;
	assign data_pull = (cnt < twae_pkg::ACK_BIT) ? transmitting & ~shreg[7] : ack_en; // [RULE24]

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !en) begin
			sda_oe_n_out <= 1'b1;
		end else if (m_ovr) begin
			sda_oe_n_out <= ~m_force;
		end else if (arb_bit) begin
			sda_oe_n_out <= 1'b1;
		end else if (!scl_s) begin
			sda_oe_n_out <= ~data_pull;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// Arbitration loss sources
	assign arb_bit = en & m_act & scl_rise & sda_oe_n_out & ~sda_s
		& (((cnt <= twae_pkg::LAST_DATA_BIT) & tx)
		| ((cnt == twae_pkg::ACK_BIT) & ~tx)); // [RULE18]
	assign arb_busy = wr_ctl & en & wdata_in[twae_pkg::CTL_MASTER]
		& ~master_select & busy; // [RULE19]
	assign arb_repeat_start_request = wr_ctl & wdata_in[twae_pkg::CTL_REPEAT_START] & ~master_select; // [RULE19]
	assign arb_stop = stop_ev & m_act & (mstate != M_STOP); // [RULE19]
	assign ev_arb = arb_bit | arb_busy | arb_repeat_start_request | arb_stop;

	// Master sequencer: start, byte clocking, repeated start, stop
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !en || arb_bit || arb_stop) begin
			mstate <= M_IDLE;
			scl_oe_n_out <= 1'b1;
			m_ovr <= 1'b0;
			m_force <= 1'b0;
			m_step <= 1'b0;
			m_go <= 1'b0;
			tmr <= twae_pkg::RST_TIMER;
		end else begin
			if (wr_dat || rd_dat) begin
				m_go <= 1'b1;
			end
			unique case (mstate)
				M_IDLE: begin
					m_ovr <= 1'b0;
					// Byte requests seen before mastership must not start a transfer
					m_go <= 1'b0;
					if (wr_ctl && wdata_in[twae_pkg::CTL_MASTER] && !master_select && !busy) begin
						mstate <= M_START;
						m_ovr <= 1'b1;
						m_force <= 1'b1;
						tmr <= half - 10'h001;
					end
				end
				M_START: begin
					if (tmr == 10'h000) begin
						scl_oe_n_out <= 1'b0;
						m_ovr <= 1'b0;
						mstate <= M_HOLD;
					end else begin
						tmr <= tmr - 10'h001;
					end
				end
				M_HOLD: begin
					tmr <= half - 10'h001;
					m_step <= 1'b0;
					if (!master_select) begin
						mstate <= M_STOP;
						m_ovr <= 1'b1;
						m_force <= 1'b1;
					end else if (wr_ctl && wdata_in[twae_pkg::CTL_REPEAT_START]) begin
						mstate <= M_RESTART;
						m_ovr <= 1'b1;
						m_force <= 1'b0;
					end else if (m_go) begin
						mstate <= M_XFER;
						m_go <= wr_dat | rd_dat;
					end
				end
				M_XFER: begin
					if (!scl_oe_n_out) begin
						if (tmr == 10'h000) begin
							scl_oe_n_out <= 1'b1;
							tmr <= half - 10'h001;
						end else begin
							tmr <= tmr - 10'h001;
						end
					end else if (scl_s) begin
						if (tmr == 10'h000) begin
							scl_oe_n_out <= 1'b0;
							tmr <= half - 10'h001;
							if (cnt == twae_pkg::ACK_BIT) begin
								mstate <= M_HOLD;
							end
						end else begin
							tmr <= tmr - 10'h001;
						end
					end
				end
				default: begin
					// Repeated start and stop: wait low half, release clock, wait high half
					if (!m_step) begin
						if (tmr == 10'h000) begin
							scl_oe_n_out <= 1'b1;
							m_step <= 1'b1;
							tmr <= half - 10'h001;
						end else begin
							tmr <= tmr - 10'h001;
						end
					end else if (scl_s) begin
						if (tmr != 10'h000) begin
							tmr <= tmr - 10'h001;
						end else if (mstate == M_RESTART) begin
							m_force <= 1'b1;
							tmr <= half - 10'h001;
							mstate <= M_START;
						end else if (m_force) begin
							m_force <= 1'b0;
						end else if (!busy) begin
							mstate <= M_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Software registers
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			own_slave_address <= twae_pkg::RST_BYTE;
			baud_divider <= twae_pkg::RST_BYTE;
			address_config <= twae_pkg::RST_BYTE;
		end else if (wr_in) begin
			if (twae_hit(addr_in, twae_pkg::OFF_OWN_SLAVE_ADDRESS)) begin
				own_slave_address <= {wdata_in[7:1], 1'b0}; // [RULE22]
			end
			if (twae_hit(addr_in, twae_pkg::OFF_BAUD_DIVIDER)) begin
				baud_divider <= wdata_in;
			end
			if (twae_hit(addr_in, twae_pkg::OFF_ADDRESS_CONFIG)) begin
				address_config <= {wdata_in[7:6], 3'b000, wdata_in[2:0]};
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			{en, ie, master_select, tx, ack_disable} <= 5'b00000; // [RULE11]
		end else begin
			if (wr_ctl) begin
				en <= wdata_in[twae_pkg::CTL_ENABLE];
				ie <= wdata_in[twae_pkg::CTL_IRQ_ENABLE];
				master_select <= wdata_in[twae_pkg::CTL_MASTER] & (master_select | ~busy);
				tx <= wdata_in[twae_pkg::CTL_TX];
				ack_disable <= wdata_in[twae_pkg::CTL_ACK_DISABLE];
			end
			if (arb_bit || arb_stop || !en) begin
				master_select <= 1'b0;
			end
		end
	end

	// Status flags: hardware set wins over software clear
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !en) begin
			{byte_done_flag, addressed_as_slave, busy, arbitration_lost} <= 4'b0000;
			{slave_direction, bus_irq_flag, received_ack} <= 3'b000;
		end else begin
			busy <= (busy | start_ev) & ~stop_ev;
			byte_done_flag <= ev_byte | (byte_done_flag & ~(wr_dat | rd_dat)); // [RULE15]
			addressed_as_slave <= (dec & set_addressed)
				| (addressed_as_slave & ~wr_ctl & ~start_ev); // [RULE25]
			arbitration_lost <= ev_arb
				| (arbitration_lost & ~(wr_sts & wdata_in[twae_pkg::STS_ARB_LOST])); // [RULE20]
			bus_irq_flag <= ev_byte | (dec & (set_addressed | ev10)) | ev_arb
				| (bus_irq_flag & ~(wr_sts & wdata_in[twae_pkg::STS_IRQ_FLAG])); // [RULE13] [RULE14]
			if (dec) begin
				slave_direction <= next_slave_direction;
			end
			if (en && scl_rise && cnt == twae_pkg::ACK_BIT) begin
				received_ack <= sda_s;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= bus_irq_flag & ie; // [RULE12]
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !rd_in) begin
			rdata_out <= twae_pkg::RST_BYTE;
		end else begin
			unique case (addr_in)
				twae_pkg::OFF_OWN_SLAVE_ADDRESS: rdata_out <= own_slave_address;
				twae_pkg::OFF_BAUD_DIVIDER: rdata_out <= baud_divider;
				twae_pkg::OFF_MAIN_CONTROL: rdata_out <= {en, ie, master_select, tx, ack_disable, 3'b000};
				twae_pkg::OFF_BUS_STATUS: rdata_out <= {byte_done_flag, addressed_as_slave,
					busy, arbitration_lost, 1'b0, slave_direction, bus_irq_flag, received_ack};
				twae_pkg::OFF_TRANSFER_BYTE: rdata_out <= shreg; // [RULE9]
				twae_pkg::OFF_ADDRESS_CONFIG: rdata_out <= address_config;
				default: rdata_out <= twae_pkg::RST_BYTE;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	irq_gate_a: assert property (##1 irq_out == $past(bus_irq_flag & ie)) // [RULE12]
		else $error("irq output not gated flag");
	flag_clear_a: assert property (bus_irq_flag && en
		&& !(wr_sts && wdata_in[twae_pkg::STS_IRQ_FLAG]) |=> bus_irq_flag) // [RULE13]
		else $error("irq flag cleared without write of one");
	byte_done_a: assert property (ev_byte |=> byte_done_flag && bus_irq_flag) // [RULE15]
		else $error("byte done flag missing after ninth fall");
	arb_hold_a: assert property (arbitration_lost && en
		&& !(wr_sts && wdata_in[twae_pkg::STS_ARB_LOST]) |=> arbitration_lost) // [RULE20]
		else $error("arbitration lost bit dropped");
	busy_start_a: assert property (arb_busy && en |=> arbitration_lost && !master_select) // [RULE19]
		else $error("start while busy not flagged");
	ten_first_a: assert property (dec && !m_act && ph == PH_ADDR && !gc_hit
		&& address_config[twae_pkg::CFG_TEN_BIT] && pre_hit && !abyte[0]
		|=> ack_en && ph == PH_ADDR2 && bus_irq_flag) // [RULE2]
		else $error("ten-bit first byte not acknowledged");
	gen_off_a: assert property (dec && !m_act && ph == PH_ADDR && gc_hit
		&& !address_config[twae_pkg::CFG_GEN_CALL] |=> !ack_en && ph == PH_SKIP) // [RULE10]
		else $error("general call acknowledged while disabled");
	addr_irq_a: assert property ($rose(addressed_as_slave) |-> bus_irq_flag) // [RULE14]
		else $error("address match did not raise irq flag");
endmodule : twae_ctrl

// ===== verif/twae_bus_master.sv
/*
 * Behavioural master standing on the far side of the two-wire pins.
 * Assumes the bench resolves both open-drain lines and feeds them back.
 */
module twae_bus_master (
	input wire logic ref_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_drv_out,
	output logic sda_drv_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Slow pacing, the slave never stretches
	localparam int HALF = 10;
	initial begin
		scl_drv_out = 1'b1;
		sda_drv_out = 1'b1;
	end
	task automatic half_wait;
		repeat (HALF) @(posedge ref_clk_in);
	endtask : half_wait
	// Works from idle and as a repeated start
	task automatic start_cond;
		sda_drv_out <= 1'b1;
		half_wait();
		scl_drv_out <= 1'b1;
		half_wait();
		sda_drv_out <= 1'b0;
		half_wait();
		scl_drv_out <= 1'b0;
		half_wait();
	endtask : start_cond
	task automatic stop_cond;
		sda_drv_out <= 1'b0;
		half_wait();
		scl_drv_out <= 1'b1;
		half_wait();
		sda_drv_out <= 1'b1;
		half_wait();
	endtask : stop_cond
	// One clock pulse; data set while the clock is low
	task automatic bit_cycle(input logic d, output logic s);
		sda_drv_out <= d;
		half_wait();
		scl_drv_out <= 1'b1;
		half_wait();
		s = sda_in;
		scl_drv_out <= 1'b0;
	endtask : bit_cycle
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, s);
		ack = ~s;
		half_wait();
	endtask : wbyte
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, b[i]);
		end
		// Ninth bit is the master's own acknowledge, not data
		bit_cycle(nack, s);
		half_wait();
	endtask : rbyte
	task automatic drive_data(input logic d);
		@(posedge ref_clk_in);
		sda_drv_out <= d;
	endtask : drive_data
endmodule : twae_bus_master

// ===== verif/twae_ctrl_tb.sv
/*
 * Self-checking bench for the two-wire controller core.
 * Assumes pull-ups on both lines, modelled as a wired AND below.
 */
module twae_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic irq, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
	wire scl_line = m_scl & (scl_oe_n | scl_o);
	wire sda_line = m_sda & (sda_oe_n | sda_o);
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] v;
	logic ack;
	always #(twae_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	twae_ctrl u_dut (.ref_clk_in(ref_clk), .nrst_in(nrst), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
		.scl_in(scl_line), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
		.sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n));
	twae_bus_master u_m (.ref_clk_in(ref_clk), .scl_in(scl_line), .sda_in(sda_line),
		.scl_drv_out(m_scl), .sda_drv_out(m_sda));
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(posedge ref_clk);
		d = rdata;
	endtask : rd_reg
	task automatic sts(input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] s;
		rd_reg(twae_pkg::OFF_BUS_STATUS, s);
		check(s & mask, exp);
	endtask : sts
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rd_reg(i[2:0], v);
			check(v, 8'h00);
		end
		check({7'h00, irq}, 8'h00);
		wr_reg(3'h0, 8'hA1);
		rd_reg(3'h0, v);
		check(v, 8'hA0);
		wr_reg(3'h5, 8'hFF);
		rd_reg(3'h5, v);
		check(v, 8'hC7);
		wr_reg(3'h1, 8'h45);
		rd_reg(3'h1, v);
		check(v, 8'h45);
		wr_reg(3'h5, 8'h00);
		wr_reg(3'h2, 8'hC0);
		// Seven-bit write to own address
		u_m.start_cond();
		u_m.wbyte(8'hA0, ack);
		check({7'h00, ack}, 8'h01);
		sts(8'hFE, 8'hE2);
		check({7'h00, irq}, 8'h01);
		wr_reg(3'h3, 8'h00);
		sts(8'h02, 8'h02);
		wr_reg(3'h3, 8'h02);
		sts(8'h02, 8'h00);
		u_m.wbyte(8'h5A, ack);
		check({7'h00, ack}, 8'h01);
		rd_reg(3'h4, v);
		check(v, 8'h5A);
		wr_reg(3'h2, 8'h80);
		sts(8'h42, 8'h02);
		check({7'h00, irq}, 8'h00);
		wr_reg(3'h2, 8'hC0);
		repeat (2) @(posedge ref_clk);
		check({7'h00, irq}, 8'h01);
		u_m.stop_cond();
		wr_reg(3'h3, 8'h12);
		u_m.start_cond();
		u_m.wbyte(8'hA2, ack);
		check({7'h00, ack}, 8'h00);
		sts(8'h40, 8'h00);
		u_m.stop_cond();
		// General call, disabled then enabled
		u_m.start_cond();
		u_m.wbyte(8'h00, ack);
		check({7'h00, ack}, 8'h00);
		u_m.wbyte(8'h33, ack);
		check({7'h00, ack}, 8'h00);
		u_m.stop_cond();
		wr_reg(3'h5, 8'h80);
		u_m.start_cond();
		u_m.wbyte(8'h00, ack);
		check({7'h00, ack}, 8'h01);
		sts(8'h44, 8'h40);
		rd_reg(3'h4, v);
		check(v, 8'h00);
		u_m.stop_cond();
		wr_reg(3'h3, 8'h12);
		// Ten-bit address 0x2D0 with AD9 and AD7 set: bytes F4 then D0
		wr_reg(3'h5, 8'h45);
		u_m.start_cond();
		u_m.wbyte(8'hF4, ack);
		check({7'h00, ack}, 8'h01);
		sts(8'h42, 8'h02);
		wr_reg(3'h3, 8'h02);
		u_m.wbyte(8'hD0, ack);
		check({7'h00, ack}, 8'h01);
		sts(8'h40, 8'h40);
		u_m.start_cond();
		u_m.wbyte(8'hF5, ack);
		check({7'h00, ack}, 8'h01);
		sts(8'h44, 8'h44);
		wr_reg(3'h2, 8'hD0);
		wr_reg(3'h4, 8'hA5);
		u_m.rbyte(1'b1, v);
		check(v, 8'hA5);
		u_m.stop_cond();
		u_m.start_cond();
		u_m.wbyte(8'hF4, ack);
		u_m.wbyte(8'hD1, ack);
		check({7'h00, ack}, 8'h00);
		u_m.stop_cond();
		u_m.start_cond();
		u_m.wbyte(8'hF5, ack);
		check({7'h00, ack}, 8'h00);
		u_m.stop_cond();
		wr_reg(3'h5, 8'h05);
		u_m.start_cond();
		u_m.wbyte(8'hF4, ack);
		check({7'h00, ack}, 8'h00);
		u_m.stop_cond();
		wr_reg(3'h3, 8'h12);
		// Start attempted while another master holds the bus
		u_m.start_cond();
		wr_reg(3'h2, 8'hE0);
		sts(8'h12, 8'h12);
		rd_reg(3'h2, v);
		check(v & 8'h20, 8'h00);
		wr_reg(3'h3, 8'h00);
		sts(8'h10, 8'h10);
		wr_reg(3'h3, 8'h12);
		sts(8'h10, 8'h00);
		u_m.stop_cond();
		wr_reg(3'h2, 8'hC4);
		sts(8'h10, 8'h10);
		wr_reg(3'h3, 8'h12);
		// Own master transmit of ones against a data line held low
		wr_reg(3'h1, 8'h00);
		wr_reg(3'h2, 8'hF0);
		repeat (60) @(posedge ref_clk);
		wr_reg(3'h4, 8'hFF);
		repeat (5) @(posedge ref_clk);
		u_m.drive_data(1'b0);
		repeat (300) @(posedge ref_clk);
		sts(8'h10, 8'h10);
		rd_reg(3'h2, v);
		check(v & 8'h20, 8'h00);
		u_m.drive_data(1'b1);
		repeat (40) @(posedge ref_clk);
		final_report();
	end
endmodule : twae_ctrl_tb
